//--- bench/sync_slave_model.sv
// slave device that shifts in the data line
`timescale 1ns/10ps
`default_nettype none
module sync_slave_model
(
   input wire logic ck,
   input wire logic dt,
   output var logic [31:0] sh,
   output var int n
);
   initial
   begin
      sh = 32'h0;
      n = 0;
   end
   always @(negedge ck)
   begin
      sh = {dt, sh[31:1]};
      n = n + 1;
   end
endmodule : sync_slave_model
`default_nettype wire

//--- bench/sync_tx_monitor.sv
// port assertions for the synchronous master transmitter
`timescale 1ns/10ps
`default_nettype none
module sync_tx_monitor
   import sync_tx_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [DATA_W-1:0] RDATA,
   input wire logic CK_OUT,
   input wire logic CK_OE,
   input wire logic DT_OUT,
   input wire logic DT_OE
);
   logic [7:0] div_r;
   logic [7:0] rx_r;
   logic [9:0] hi_r;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   // shadow divisor, receive enables and clock-high length
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         div_r <= 8'h00;
         rx_r <= 8'h00;
         hi_r <= 10'h000;
      end
      else
      begin
         if (WR && ADDR == IDX_BAUD_DIV)
            div_r <= WDATA;
         if (WR && ADDR == IDX_RX_STATUS)
            rx_r <= WDATA;
         hi_r <= CK_OUT ? hi_r + 10'h001 : 10'h000;
      end
   end
   AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data not zero outside a read");
   AST_HOLD_WO: assert property (RD && ADDR == IDX_TX_HOLD |=>
      RDATA == 8'h00)
      else $error("holding register readable");
   AST_UNMAPPED: assert property (RD && ADDR > IDX_PIN_LEVEL |=>
      RDATA == 8'h00)
      else $error("unmapped read not zero");
   AST_DRIVERS_ON: assert property (CK_OUT |-> CK_OE && DT_OE)
      else $error("clock runs with a driver off");
   AST_CK_QUIET: assert property (!CK_OE |-> !CK_OUT)
      else $error("clock high while not driven");
   AST_DT_LEADING: assert property ($changed(DT_OUT) |->
      $rose(CK_OUT))
      else $error("data changed off the leading edge");
   AST_CK_HIGH: assert property ($fell(CK_OUT) |->
      hi_r == {1'b0, div_r, 1'b0} + 10'h002)
      else $error("clock high length wrong");
   AST_HALF_DUPLEX: assert property ((rx_r[5] | rx_r[4]) |=>
      !DT_OE)
      else $error("data driven in receive mode");
endmodule : sync_tx_monitor
bind sync_serial_master_tx sync_tx_monitor u_mon (.CLK(CLK),
   .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .CK_OUT(CK_OUT), .CK_OE(CK_OE), .DT_OUT(DT_OUT),
   .DT_OE(DT_OE));
`default_nettype wire

//--- bench/tb_sync_serial_master_tx.sv
// self-checking bench for the synchronous master transmitter
`timescale 1ns/10ps
`default_nettype none
module tb_sync_serial_master_tx
   import sync_tx_pkg::*;
;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [7:0] RDATA;
   logic IRQ, CK_OUT, CK_OE, DT_OUT, DT_OE;
   // pull-down on clock, pull-up on data
   wire logic ck_w = CK_OE === 1'b1 ? CK_OUT : 1'b0;
   wire logic dt_w = DT_OE === 1'b1 ? DT_OUT : 1'b1;
   int n_errors = 0;
   int compares = 0;
   int i, n, n0;
   logic [31:0] lfsr_r = 32'hF3BF;
   logic [31:0] sh;
   logic [7:0] d, c1, c2, dv;
   logic [7:0] rst_tab [8] = '{RST_GLOBAL_INT, RST_PERIPH_IE,
      RST_PERIPH_IF, RST_RX_STATUS, RST_BAUD_DIV, RST_PORTC_DIR,
      8'h00, RST_TX_STATUS};
   always #5 CLK = ~CLK;
   sync_serial_master_tx u_dut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
      .CK_IN(ck_w), .CK_OUT(CK_OUT), .CK_OE(CK_OE), .DT_IN(dt_w),
      .DT_OUT(DT_OUT), .DT_OE(DT_OE));
   sync_slave_model u_slave (.ck(ck_w), .dt(dt_w), .sh(sh), .n(n));
   function automatic logic [31:0] exp_char(input logic [7:0] c,
      input int nb, input logic x9);
      return nb == 9 ? {23'h0, x9, c} : {24'h0, c};
   endfunction : exp_char
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_step
   task automatic nxt();
      lfsr_r = lfsr_step(lfsr_r);
   endtask : nxt
   task automatic final_report();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= v;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1 v = RDATA;
   endtask : rd
   task automatic wait_bits(input int t);
      for (int k = 0; k < 4000 && n < t; k++)
         @(posedge CLK);
      if (n < t)
      begin
         n_errors++;
         final_report();
      end
   endtask : wait_bits
   task automatic send(input logic [7:0] c, input int nb, input logic x9);
      n0 = n;
      wr(IDX_TX_HOLD, c);
      rd(IDX_TX_STATUS, d);
      chk("busy", d[1], 1'b0);
      chk("drivers", {CK_OE, DT_OE}, 2'h3);
      wait_bits(n0 + nb);
      repeat (16 * (dv + 1)) @(posedge CLK);
      chk("bits", n - n0, nb);
      chk("char", sh >> (32 - nb), exp_char(c, nb, x9));
      rd(IDX_PERIPH_IF, d);
      chk("tx_flag", d[4], 1'b1);
   endtask : send
   initial
   begin
      repeat (3) @(posedge CLK);
      RST_B <= 1'b1;
      for (i = 0; i < 8; i++)
      begin
         rd(4'(i), d);
         chk("reset", d, rst_tab[i]);
      end
      rd(4'hF, d);
      chk("unmapped", d, 8'h00);
      nxt();
      wr(IDX_PORTC_DIR, lfsr_r[7:0]);
      rd(IDX_PORTC_DIR, d);
      chk("dir", d, lfsr_r[7:0]);
      wr(IDX_RX_STATUS, 8'h80);
      wr(IDX_TX_STATUS, 8'hB0);
      for (i = 0; i < 4; i++)
      begin
         nxt();
         dv = 8'(i);
         wr(IDX_BAUD_DIV, dv);
         send(i == 0 ? 8'h00 : i == 1 ? 8'hFF : lfsr_r[7:0], 8, 1'b0);
      end
      chk("irq_masked", IRQ, 1'b0);
      wr(IDX_EVT_MASK, 8'h01);
      #1 chk("irq", IRQ, 1'b1);
      rd(IDX_EVT_STATUS, d);
      chk("events", d, 8'h03);
      wr(IDX_EVT_STATUS, 8'h03);
      #1 chk("irq_clr", IRQ, 1'b0);
      wr(IDX_GLOBAL_INT, 8'hC0);
      wr(IDX_PERIPH_IE, 8'h10);
      #1 chk("irq_tx", IRQ, 1'b1);
      wr(IDX_PERIPH_IE, 8'h00);
      #1 chk("irq_tx_off", IRQ, 1'b0);
      nxt();
      c1 = lfsr_r[7:0];
      c2 = lfsr_r[15:8];
      n0 = n;
      wr(IDX_TX_HOLD, c1);
      wr(IDX_TX_HOLD, c2);
      rd(IDX_PERIPH_IF, d);
      chk("hold_full", d[4], 1'b0);
      wait_bits(n0 + 16);
      chk("pair", sh[31:16], {c2, c1});
      for (i = 0; i < 2; i++)
      begin
         nxt();
         wr(IDX_TX_STATUS, 8'hF0 | 8'(i));
         send(lfsr_r[7:0], 9, i[0]);
         rd(IDX_TX_STATUS, d);
         chk("status", d, 8'hF2 | 8'(i));
      end
      wr(IDX_RX_STATUS, 8'hA0);
      n0 = n;
      wr(IDX_TX_HOLD, 8'h5A);
      repeat (100) @(posedge CLK);
      chk("rx_mode", n - n0, 0);
      chk("dt_oe", DT_OE, 1'b0);
      chk("ck_oe", CK_OE, 1'b1);
      rd(IDX_PIN_LEVEL, d);
      chk("pins", d, 8'h01);
      wr(IDX_RX_STATUS, 8'h00);
      wr(IDX_RX_STATUS, 8'h80);
      repeat (100) @(posedge CLK);
      chk("dropped", n - n0, 0);
      // reset in mid-character
      wr(IDX_TX_HOLD, 8'hC3);
      repeat (40) @(posedge CLK);
      RST_B <= 1'b0;
      repeat (2) @(posedge CLK);
      RST_B <= 1'b1;
      #1 chk("rst_pins", {IRQ, CK_OUT, CK_OE, DT_OUT, DT_OE}, 5'h00);
      n0 = n;
      rd(IDX_TX_STATUS, d);
      chk("rst_status", d, RST_TX_STATUS);
      repeat (100) @(posedge CLK);
      chk("rst_quiet", n - n0, 0);
      final_report();
   end
endmodule : tb_sync_serial_master_tx
`default_nettype wire

//--- hdl/baud_tick.sv
// half-period tick generator for the master shift clock
`timescale 1ns/10ps
`default_nettype none
module baud_tick
   import sync_tx_pkg::*;
#(
   parameter int PRESCALE = HALF_PRESCALE
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [7:0] divisor,
   output logic tick
);

   logic [10:0] cnt_r;
   logic [10:0] cnt_nxt;
   wire [10:0] period;
   wire at_end;

   assign period = 11'(PRESCALE) * (11'(divisor) + 11'h001);
   assign at_end = run && (cnt_r == period - 11'h001);
   assign cnt_nxt = (!run || at_end) ? 11'h000 : cnt_r + 11'h001;
   assign tick = at_end;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         cnt_r <= 11'h000;
      else
         cnt_r <= cnt_nxt;
   end

endmodule : baud_tick
`default_nettype wire

//--- hdl/sync_serial_master_tx.sv
// synchronous master transmit path with register port and shift engine
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - half-duplex, data line never driven receiving
// - no start or stop bits framed
// - sync, master and enable bits select mode
// - transmit only when both receive enables clear
// - master drives clock pin, driver auto-enabled
// - data changes on leading clock edge
// - one clock per data bit, no extras
// - data leaves on data pin, drivers enabled
// - holding register write starts a transmission
// - new character waits while shifter busy
// - empty shifter loads at once and shifts
// - bit stays valid until next leading edge
// - shift register not visible to software
// - ninth bit sent when nine-bit mode chosen
module sync_serial_master_tx
   import sync_tx_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DATA_W-1:0] RDATA,
   output logic IRQ,
   input wire logic CK_IN,
   output logic CK_OUT,
   output logic CK_OE,
   input wire logic DT_IN,
   output logic DT_OUT,
   output logic DT_OE
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOW,
      ST_HIGH
   } shift_state_t;

   // software registers
   logic [7:0] global_int_r;
   logic [7:0] periph_ie_r;
   logic [7:0] periph_if_r;
   rx_status_t rx_status_r;
   logic [7:0] baud_div_r;
   logic [7:0] portc_dir_r;
   tx_status_t tx_status_r;
   logic [EVT_W-1:0] evt_status_r;
   logic [EVT_W-1:0] evt_status_nxt;
   logic [EVT_W-1:0] evt_mask_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;

   // transmit holding and hidden shifter
   logic [7:0] hold_r;
   logic hold_full_r;
   logic hold_full_nxt;
   logic [8:0] shift_r;
   logic [8:0] shift_nxt;
   logic [3:0] bits_left_r;
   logic [3:0] bits_left_nxt;
   shift_state_t state_r;
   shift_state_t state_nxt;
   pin_drive_t pins_r;
   pin_drive_t pins_nxt;

   // pin synchronisers
   logic [1:0] ck_sync_r;
   logic [1:0] dt_sync_r;

   // decode
   wire wr_global_int = WR && (ADDR == IDX_GLOBAL_INT);
   wire wr_periph_ie = WR && (ADDR == IDX_PERIPH_IE);
   wire wr_periph_if = WR && (ADDR == IDX_PERIPH_IF);
   wire wr_rx_status = WR && (ADDR == IDX_RX_STATUS);
   wire wr_baud_div = WR && (ADDR == IDX_BAUD_DIV);
   wire wr_portc_dir = WR && (ADDR == IDX_PORTC_DIR);
   wire wr_tx_hold = WR && (ADDR == IDX_TX_HOLD);
   wire wr_tx_status = WR && (ADDR == IDX_TX_STATUS);
   wire wr_evt_status = WR && (ADDR == IDX_EVT_STATUS);
   wire wr_evt_mask = WR && (ADDR == IDX_EVT_MASK);

   // mode selection
   // mode select bits
   wire master_sync = rx_status_r.serial_port_enable
      && tx_status_r.sync_mode_select
      && tx_status_r.clock_source_master;
   wire rx_cfg = rx_status_r.single_receive_enable
      || rx_status_r.continuous_receive_enable;
   wire tx_mode = master_sync && !rx_cfg && tx_status_r.transmit_enable;
   // clock driver on for transmit or receive
   wire ck_drive = master_sync
      && (tx_status_r.transmit_enable || rx_cfg);
   // data driver off whenever receive is set
   // data driver on in master transmit
   wire dt_drive = tx_mode;

   wire shifter_empty = (state_r == ST_IDLE);
   // holding waits for an idle shifter
   // empty shifter takes holding at once
   wire load = tx_mode && hold_full_r && shifter_empty;
   wire tick;
   wire last_edge = tick && (state_r == ST_HIGH)
      && (bits_left_r == 4'h0);

   wire tx_int_flag = tx_status_r.transmit_enable && !hold_full_r;
   wire [7:0] periph_if_view = {periph_if_r[7:BIT_TX_INT_FLAG+1], tx_int_flag,
      periph_if_r[BIT_TX_INT_FLAG-1:0]};
   tx_status_t tx_status_view;
   assign tx_status_view = '{
      clock_source_master: tx_status_r.clock_source_master,
      nine_bit_tx: tx_status_r.nine_bit_tx,
      transmit_enable: tx_status_r.transmit_enable,
      sync_mode_select: tx_status_r.sync_mode_select,
      unused3: 1'b0,
      high_speed_baud: tx_status_r.high_speed_baud,
      shift_empty_flag: shifter_empty,
      tx_ninth_bit: tx_status_r.tx_ninth_bit
   };
   wire [7:0] rx_status_view = {rx_status_r[7:3], 3'h0};
   wire [7:0] pin_level_view = {6'h00, ck_sync_r[1], dt_sync_r[1]};

   wire tx_irq = global_int_r[BIT_GIE] && global_int_r[BIT_PERIPHERAL_INT_ENABLE_GATE]
      && periph_ie_r[BIT_TX_INT_ENABLE] && tx_int_flag;
   wire evt_irq = |(evt_status_r & evt_mask_r);
   wire [EVT_W-1:0] evt_set = {load, last_edge};

   // read mux
   // shifter has no read path
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (RD)
      begin
         unique case (ADDR)
            IDX_GLOBAL_INT: rdata_nxt = global_int_r;
            IDX_PERIPH_IE: rdata_nxt = periph_ie_r;
            IDX_PERIPH_IF: rdata_nxt = periph_if_view;
            IDX_RX_STATUS: rdata_nxt = rx_status_view;
            IDX_BAUD_DIV: rdata_nxt = baud_div_r;
            IDX_PORTC_DIR: rdata_nxt = portc_dir_r;
            IDX_TX_STATUS: rdata_nxt = tx_status_view;
            IDX_EVT_STATUS: rdata_nxt = {6'h00, evt_status_r};
            IDX_EVT_MASK: rdata_nxt = {6'h00, evt_mask_r};
            IDX_PIN_LEVEL: rdata_nxt = pin_level_view;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // sticky events, set beats write-one clear
   assign evt_status_nxt = (evt_status_r
      & ~(wr_evt_status ? WDATA[EVT_W-1:0] : {EVT_W{1'b0}})) | evt_set;

   // holding register occupancy
   // write to holding starts a send
   always_comb
   begin
      hold_full_nxt = hold_full_r;
      if (!rx_status_r.serial_port_enable)
         hold_full_nxt = 1'b0;
      else if (wr_tx_hold)
         hold_full_nxt = 1'b1;
      else if (load)
         hold_full_nxt = 1'b0;
   end

   baud_tick #(
      .PRESCALE(HALF_PRESCALE)
   ) u_baud (
      .clk(CLK),
      .rst_b(RST_B),
      .run(!shifter_empty),
      .divisor(baud_div_r),
      .tick(tick)
   );

   // shift engine
   always_comb
   begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      bits_left_nxt = bits_left_r;
      pins_nxt = pins_r;
      pins_nxt.ck_oe = ck_drive;
      pins_nxt.dt_oe = dt_drive;
      if (!tx_mode)
      begin
         state_nxt = ST_IDLE;
         pins_nxt.ck_out = 1'b0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               if (load)
               begin
                  shift_nxt = {tx_status_r.tx_ninth_bit, hold_r};
                  bits_left_nxt = tx_status_r.nine_bit_tx
                     ? BITS_NINE : BITS_EIGHT;
                  state_nxt = ST_LOW;
               end
            end
            ST_LOW:
            begin
               if (tick)
               begin
                  // data changes with the leading edge
                  // held until the next leading edge
                  pins_nxt.ck_out = 1'b1;
                  pins_nxt.dt_out = shift_r[0];
                  shift_nxt = {1'b0, shift_r[8:1]};
                  bits_left_nxt = bits_left_r - 4'h1;
                  state_nxt = ST_HIGH;
               end
            end
            ST_HIGH:
            begin
               if (tick)
               begin
                  pins_nxt.ck_out = 1'b0;
                  // stop after the last data bit
                  state_nxt = (bits_left_r == 4'h0) ? ST_IDLE : ST_LOW;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         state_r <= ST_IDLE;
         shift_r <= 9'h000;
         bits_left_r <= 4'h0;
         pins_r <= '0;
         hold_full_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         bits_left_r <= bits_left_nxt;
         pins_r <= pins_nxt;
         hold_full_r <= hold_full_nxt;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         global_int_r <= RST_GLOBAL_INT;
         periph_ie_r <= RST_PERIPH_IE;
         periph_if_r <= RST_PERIPH_IF;
         rx_status_r <= RST_RX_STATUS;
         baud_div_r <= RST_BAUD_DIV;
         portc_dir_r <= RST_PORTC_DIR;
         hold_r <= RST_TX_HOLD;
         tx_status_r <= RST_TX_STATUS;
      end
      else
      begin
         if (wr_global_int)
            global_int_r <= WDATA;
         if (wr_periph_ie)
            periph_ie_r <= WDATA;
         if (wr_periph_if)
            periph_if_r <= WDATA;
         if (wr_rx_status)
            rx_status_r <= {WDATA[7:3], 3'h0};
         if (wr_baud_div)
            baud_div_r <= WDATA;
         if (wr_portc_dir)
            portc_dir_r <= WDATA;
         if (wr_tx_hold)
            hold_r <= WDATA;
         if (wr_tx_status)
            tx_status_r <= {WDATA[7:4], 1'b0, WDATA[2], 1'b0, WDATA[0]};
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         evt_status_r <= RST_EVT;
         evt_mask_r <= RST_EVT;
         rdata_r <= 8'h00;
      end
      else
      begin
         evt_status_r <= evt_status_nxt;
         if (wr_evt_mask)
            evt_mask_r <= WDATA[EVT_W-1:0];
         rdata_r <= rdata_nxt;
      end
   end

   // two-flop pin synchronisers
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         ck_sync_r <= 2'h0;
         dt_sync_r <= 2'h0;
      end
      else
      begin
         ck_sync_r <= {ck_sync_r[0], CK_IN};
         dt_sync_r <= {dt_sync_r[0], DT_IN};
      end
   end

   assign RDATA = rdata_r;
   assign IRQ = tx_irq || evt_irq;
   assign CK_OUT = pins_r.ck_out;
   assign CK_OE = pins_r.ck_oe;
   assign DT_OUT = pins_r.dt_out;
   assign DT_OE = pins_r.dt_oe;

endmodule : sync_serial_master_tx
`default_nettype wire

//--- include/sync_tx_pkg.sv
// shared constants and types for the synchronous master transmitter
package sync_tx_pkg;

   // register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // register indices
   localparam logic [3:0] IDX_GLOBAL_INT = 4'h0;
   localparam logic [3:0] IDX_PERIPH_IE = 4'h1;
   localparam logic [3:0] IDX_PERIPH_IF = 4'h2;
   localparam logic [3:0] IDX_RX_STATUS = 4'h3;
   localparam logic [3:0] IDX_BAUD_DIV = 4'h4;
   localparam logic [3:0] IDX_PORTC_DIR = 4'h5;
   localparam logic [3:0] IDX_TX_HOLD = 4'h6;
   localparam logic [3:0] IDX_TX_STATUS = 4'h7;
   localparam logic [3:0] IDX_EVT_STATUS = 4'h8;
   localparam logic [3:0] IDX_EVT_MASK = 4'h9;
   localparam logic [3:0] IDX_PIN_LEVEL = 4'hA;

   // reset values
   localparam logic [7:0] RST_GLOBAL_INT = 8'h00;
   localparam logic [7:0] RST_PERIPH_IE = 8'h00;
   localparam logic [7:0] RST_PERIPH_IF = 8'h00;
   localparam logic [7:0] RST_RX_STATUS = 8'h00;
   localparam logic [7:0] RST_BAUD_DIV = 8'h00;
   localparam logic [7:0] RST_PORTC_DIR = 8'hFF;
   localparam logic [7:0] RST_TX_HOLD = 8'h00;
   localparam logic [7:0] RST_TX_STATUS = 8'h02;
   localparam logic [1:0] RST_EVT = 2'h0;

   // field positions
   localparam int BIT_GIE = 7;
   localparam int BIT_PERIPHERAL_INT_ENABLE_GATE = 6;
   localparam int BIT_TX_INT_ENABLE = 4;
   localparam int BIT_TX_INT_FLAG = 4;
   localparam int EVT_CHAR_DONE = 0;
   localparam int EVT_HOLD_TAKEN = 1;
   localparam int EVT_W = 2;

   // character lengths
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;

   // clock cycles per half shift-clock period per divisor step
   localparam int HALF_PRESCALE = 2;

   typedef struct packed {
      logic clock_source_master;
      logic nine_bit_tx;
      logic transmit_enable;
      logic sync_mode_select;
      logic unused3;
      logic high_speed_baud;
      logic shift_empty_flag;
      logic tx_ninth_bit;
   } tx_status_t;

   typedef struct packed {
      logic serial_port_enable;
      logic rx_nine_bit;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic addr_detect;
      logic frame_err;
      logic overrun_err;
      logic rx_ninth_bit;
   } rx_status_t;

   typedef struct packed {
      logic ck_out;
      logic ck_oe;
      logic dt_out;
      logic dt_oe;
   } pin_drive_t;

endpackage : sync_tx_pkg
